// [common/timer_pkg.sv]
// Constants, offsets, field positions and encodings of the timer block.
package timer_pkg;

  // Register indices; the APB byte address of each is four times the index.
  localparam logic [11:0] IDX_CNT_H = 12'hf00;
  localparam logic [11:0] IDX_CNT_L = 12'hf01;
  localparam logic [11:0] IDX_RLD_H = 12'hf02;
  localparam logic [11:0] IDX_RLD_L = 12'hf03;
  localparam logic [11:0] IDX_CMP_H = 12'hf04;
  localparam logic [11:0] IDX_CMP_L = 12'hf05;
  localparam logic [11:0] IDX_CTL0 = 12'hf06;
  localparam logic [11:0] IDX_CTL1 = 12'hf07;
  localparam logic [11:0] IDX_CAP2_H = 12'hf20;
  localparam logic [11:0] IDX_CAP2_L = 12'hf21;
  localparam logic [11:0] IDX_STATUS = 12'hf30;
  localparam logic [11:0] IDX_MASK = 12'hf31;

  // Field positions of timer_control_one.
  localparam int CTL1_ENABLE = 7;
  localparam int CTL1_POLARITY = 6;
  localparam int CTL1_PRE_HI = 5;
  localparam int CTL1_PRE_LO = 3;
  localparam int CTL1_MODE_HI = 2;
  localparam int CTL1_MODE_LO = 0;

  // Field positions of timer_control_zero.
  localparam int CTL0_MODE3 = 7;
  localparam int CTL0_ICFG_HI = 6;
  localparam int CTL0_ICFG_LO = 5;

  // Status and mask bit positions.
  localparam int ST_RELOAD = 0;
  localparam int ST_CAPTURE = 1;

  // Reset and restart values.
  localparam logic [15:0] CNT_RESET = 16'h0001;
  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [15:0] RLD_RESET = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] FLAGS_RESET = 2'h0;

  // Timer modes, the top bit sits in timer_control_zero.
  localparam logic [3:0] MODE_ONE_SHOT = 4'h0;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
  localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
  localparam logic [3:0] MODE_CAPTURE = 4'h4;
  localparam logic [3:0] MODE_CAP_CMP = 4'h7;
  localparam logic [3:0] MODE_CAP_RESTART = 4'h9;
  localparam logic [3:0] MODE_DEMOD = 4'hc;

  // Encodings of interrupt_event_select.
  localparam logic [1:0] ICFG_CAPTURE_ONLY = 2'h2;
  localparam logic [1:0] ICFG_RELOAD_ONLY = 2'h3;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } run_state_t;

endpackage

// [common/timer_link_if.sv]
// Signals between the timer core, its prescaler and its input synchroniser.
interface timer_link_if;
  logic run;
  logic [2:0] prescale;
  logic tick;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  modport core (output run, output prescale, input tick, input pin_level, input pin_rise, input pin_fall);
  modport presc (input run, input prescale, output tick);
  modport sync (output pin_level, output pin_rise, output pin_fall);
endinterface

// [src/timer_prescaler.sv]
// Power-of-two prescaler that gives the timer one tick pulse per prescaled period.
module timer_prescaler
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the core.
  timer_link_if.presc lnk
);
  logic [6:0] div_q;
  logic tick_q;
  logic [6:0] mask;

  assign mask = 7'((8'h01 << lnk.prescale) - 8'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else if (!lnk.run)
    begin
      div_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 7'h01;
      tick_q <= (div_q & mask) == mask;
    end
  end

  assign lnk.tick = tick_q;
endmodule

// [src/timer_input_sync.sv]
// Three-stage synchroniser and edge detector for the timer input pin.
module timer_input_sync
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin.
  input wire logic pin_in,
  // Link to the core.
  timer_link_if.sync lnk
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic rise_q;
  logic fall_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      rise_q <= (s2_q == s3_q) && s3_q && !level_q;
      fall_q <= (s2_q == s3_q) && !s3_q && level_q;
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
      end
    end
  end

  assign lnk.pin_level = level_q;
  assign lnk.pin_rise = rise_q;
  assign lnk.pin_fall = fall_q;
endmodule

// [src/timer_pwm_capture_unit.sv]
// Sixteen-bit PWM and capture timer with an APB register port.
module timer_pwm_capture_unit
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins.
  input wire logic timer_in,
  output logic timer_out,
  // Interrupt.
  output logic irq
);
  timer_link_if lnk();

  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [15:0] cmp_q;
  logic [15:0] cap2_q;
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [1:0] status_set;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic out_q;
  logic irq_q;
  timer_pkg::run_state_t state_q;

  logic xfer;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic addr_ok;
  logic enable;
  logic polarity;
  logic [3:0] mode;
  logic [1:0] icfg;
  logic running;
  logic reload_hit;
  logic reload_ev;
  logic match_ev;
  logic cap_mode;
  logic cap_edge;
  logic cap_ev;

  // Byte-address decode of one register index.
  function automatic logic is_reg(input logic [15:0] a, input logic [11:0] idx);
    is_reg = a == {2'b00, idx, 2'b00};
  endfunction

  timer_prescaler u_presc
  (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk)
  );

  timer_input_sync u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(timer_in),
    .lnk(lnk)
  );

  // The access phase always takes one wait state so read data comes from a flop.
  assign xfer = psel && penable && pready_q;
  assign wr = xfer && pwrite && addr_ok;
  assign rd = xfer && !pwrite;
  assign wbyte = pwdata[7:0];

  assign enable = ctl1_q[timer_pkg::CTL1_ENABLE];
  assign polarity = ctl1_q[timer_pkg::CTL1_POLARITY];
  assign mode = {ctl0_q[timer_pkg::CTL0_MODE3], ctl1_q[timer_pkg::CTL1_MODE_HI:timer_pkg::CTL1_MODE_LO]};
  assign icfg = ctl0_q[timer_pkg::CTL0_ICFG_HI:timer_pkg::CTL0_ICFG_LO];
  assign running = state_q == timer_pkg::ST_RUN;

  assign lnk.run = running;
  assign lnk.prescale = ctl1_q[timer_pkg::CTL1_PRE_HI:timer_pkg::CTL1_PRE_LO];

  assign reload_hit = count_q == reload_q;
  assign reload_ev = running && lnk.tick && reload_hit;
  assign match_ev = running && lnk.tick && (count_q == cmp_q);

  assign cap_mode = (mode == timer_pkg::MODE_CAPTURE) || (mode == timer_pkg::MODE_CAP_CMP) ||
    (mode == timer_pkg::MODE_CAP_RESTART) || (mode == timer_pkg::MODE_DEMOD);
  // Demodulation captures both edges, the other modes take the selected one.
  assign cap_edge = (mode == timer_pkg::MODE_DEMOD) ? (lnk.pin_rise || lnk.pin_fall) :
    (polarity ? lnk.pin_fall : lnk.pin_rise);
  assign cap_ev = running && cap_mode && cap_edge;

  // Run control; one-shot parks in halt until software clears the enable bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= timer_pkg::ST_IDLE;
    end
    else
    begin
      case (state_q)
        timer_pkg::ST_IDLE:
        begin
          if (enable)
          begin
            state_q <= timer_pkg::ST_RUN;
          end
        end
        timer_pkg::ST_RUN:
        begin
          if (!enable)
          begin
            state_q <= timer_pkg::ST_IDLE;
          end
          else if (reload_ev && mode == timer_pkg::MODE_ONE_SHOT)
          begin
            state_q <= timer_pkg::ST_HALT;
          end
        end
        timer_pkg::ST_HALT:
        begin
          if (!enable)
          begin
            state_q <= timer_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_q <= timer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Counter; a software write of a count byte wins over counting in that cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= timer_pkg::CNT_RESET;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_CNT_H))
    begin
      count_q[15:8] <= wbyte;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_CNT_L))
    begin
      count_q[7:0] <= wbyte;
    end
    else if (cap_ev && mode == timer_pkg::MODE_CAP_RESTART)
    begin
      count_q <= timer_pkg::CNT_RESTART;
    end
    else if (reload_ev)
    begin
      count_q <= timer_pkg::CNT_RESTART;
    end
    else if (running && lnk.tick)
    begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reload_q <= timer_pkg::RLD_RESET;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_RLD_H))
    begin
      reload_q[15:8] <= wbyte;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_RLD_L))
    begin
      reload_q[7:0] <= wbyte;
    end
  end

  // Compare/capture pair; a capture edge or a software write loads it, never a reload.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_q <= {timer_pkg::BYTE_RESET, timer_pkg::BYTE_RESET};
    end
    else if (cap_ev && (mode != timer_pkg::MODE_DEMOD || lnk.pin_rise))
    begin
      cmp_q <= count_q;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_CMP_H))
    begin
      cmp_q[15:8] <= wbyte;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_CMP_L))
    begin
      cmp_q[7:0] <= wbyte;
    end
  end

  // Second capture pair, loaded on the falling edge in demodulation mode.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap2_q <= {timer_pkg::BYTE_RESET, timer_pkg::BYTE_RESET};
    end
    else if (cap_ev && mode == timer_pkg::MODE_DEMOD && lnk.pin_fall)
    begin
      cap2_q <= count_q;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_CAP2_H))
    begin
      cap2_q[15:8] <= wbyte;
    end
    else if (wr && is_reg(paddr, timer_pkg::IDX_CAP2_L))
    begin
      cap2_q[7:0] <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl0_q <= timer_pkg::BYTE_RESET;
      ctl1_q <= timer_pkg::BYTE_RESET;
      mask_q <= timer_pkg::FLAGS_RESET;
    end
    else if (wr)
    begin
      if (is_reg(paddr, timer_pkg::IDX_CTL0))
      begin
        ctl0_q <= wbyte;
      end
      if (is_reg(paddr, timer_pkg::IDX_CTL1))
      begin
        ctl1_q <= wbyte;
      end
      if (is_reg(paddr, timer_pkg::IDX_MASK))
      begin
        mask_q <= wbyte[1:0];
      end
    end
  end

  // Output pin. Idle PWM sits at the polarity level so the first period starts right.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= 1'b0;
    end
    else if (mode == timer_pkg::MODE_PWM_SINGLE)
    begin
      if (!running || reload_ev)
      begin
        out_q <= polarity;
      end
      else if (match_ev)
      begin
        out_q <= !polarity;
      end
    end
    else if (mode == timer_pkg::MODE_ONE_SHOT || mode == timer_pkg::MODE_CONTINUOUS)
    begin
      if (reload_ev)
      begin
        out_q <= !out_q;
      end
    end
  end

  // Event selection narrows which events raise a flag.
  always_comb
  begin
    status_set = timer_pkg::FLAGS_RESET;
    status_set[timer_pkg::ST_RELOAD] = reload_ev && icfg != timer_pkg::ICFG_CAPTURE_ONLY;
    status_set[timer_pkg::ST_CAPTURE] = cap_ev && icfg != timer_pkg::ICFG_RELOAD_ONLY;
  end

  // A read clears only the flags that it returned, so an event that lands during the access is kept.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= timer_pkg::FLAGS_RESET;
    end
    else if (rd && is_reg(paddr, timer_pkg::IDX_STATUS))
    begin
      status_q <= (status_q & ~prdata_q[1:0]) | status_set;
    end
    else
    begin
      status_q <= status_q | status_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // Read mux; the count reads live, so software sees the running value.
  always_comb
  begin
    rd_byte = timer_pkg::BYTE_RESET;
    addr_ok = 1'b1;
    if (is_reg(paddr, timer_pkg::IDX_CNT_H))
      rd_byte = count_q[15:8];
    else if (is_reg(paddr, timer_pkg::IDX_CNT_L))
      rd_byte = count_q[7:0];
    else if (is_reg(paddr, timer_pkg::IDX_RLD_H))
      rd_byte = reload_q[15:8];
    else if (is_reg(paddr, timer_pkg::IDX_RLD_L))
      rd_byte = reload_q[7:0];
    else if (is_reg(paddr, timer_pkg::IDX_CMP_H))
      rd_byte = cmp_q[15:8];
    else if (is_reg(paddr, timer_pkg::IDX_CMP_L))
      rd_byte = cmp_q[7:0];
    else if (is_reg(paddr, timer_pkg::IDX_CTL0))
      rd_byte = ctl0_q;
    else if (is_reg(paddr, timer_pkg::IDX_CTL1))
      rd_byte = ctl1_q;
    else if (is_reg(paddr, timer_pkg::IDX_CAP2_H))
      rd_byte = cap2_q[15:8];
    else if (is_reg(paddr, timer_pkg::IDX_CAP2_L))
      rd_byte = cap2_q[7:0];
    else if (is_reg(paddr, timer_pkg::IDX_STATUS))
      rd_byte = {6'h00, status_q};
    else if (is_reg(paddr, timer_pkg::IDX_MASK))
      rd_byte = {6'h00, mask_q};
    else
      addr_ok = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addr_ok;
      if (psel && penable && !pready_q && !pwrite)
      begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_out = out_q;
  assign irq = irq_q;
endmodule

// [verification/timer_pin_model.sv]
// Model of the signal source that drives the timer input pin.
module timer_pin_model
(
  // Clock.
  input wire logic pclk,
  // Pin.
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pin_out = 1'b0;

  // Levels move just after a clock edge so that capture latency is repeatable.
  // A real source is asynchronous and the synchroniser adds one cycle of jitter.
  task automatic drive(input logic lvl);
    @(posedge pclk);
    pin_out <= lvl;
  endtask
endmodule

// [verification/timer_pwm_capture_unit_checker.sv]
// Checker that watches the APB and interrupt ports of the timer block.
module timer_pwm_capture_unit_checker
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer pins and interrupt.
  input wire logic timer_in,
  input wire logic timer_out,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  byte_read_a: assert property (pready && !pwrite |-> prdata[31:8] == '0)
    else $error("upper read bits set");
  bad_read_a: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("unmapped read not zero");
  read_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved");
  // The request may only fall within three cycles after a completed APB transfer.
  irq_clear_a: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2) || $past(pready, 3))
    else $error("irq dropped by itself");
endmodule

bind timer_pwm_capture_unit timer_pwm_capture_unit_checker i_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
  .timer_out(timer_out), .irq(irq)
);

// [verification/tb.sv]
// Self-checking bench for the PWM and capture timer.
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t: got %0h want %0h", $time, (got), (exp)); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_in;
  logic timer_out;
  logic irq;
  int mismatches;
  int total_checks;
  int cyc_n;

  timer_pwm_capture_unit i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
    .timer_out(timer_out), .irq(irq)
  );
  timer_pin_model i_pin (.pclk(pclk), .pin_out(timer_in));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) cyc_n <= cyc_n + 1;

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; an idle cycle follows so the next setup never lands in the same step.
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d, output logic [7:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rd(input logic [11:0] idx, output logic [7:0] q);
    logic e;
    apb(1'b0, idx, 8'h00, q, e);
  endtask

  task automatic wr16(input logic [11:0] idx, input logic [15:0] d);
    wr(idx, d[15:8]);
    wr(idx + 12'h001, d[7:0]);
  endtask

  task automatic rd16(input logic [11:0] idx, output logic [15:0] d);
    rd(idx, d[15:8]);
    rd(idx + 12'h001, d[7:0]);
  endtask

  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (timer_out === lvl && n < 3000)
    begin
      n++;
      @(posedge pclk);
    end
  endtask

  task automatic reg_test;
    logic [11:0] idx[4] = '{timer_pkg::IDX_CMP_H, timer_pkg::IDX_CMP_L, timer_pkg::IDX_CAP2_H, timer_pkg::IDX_CAP2_L};
    logic [7:0] q;
    logic e;
    foreach (idx[i])
    begin
      rd(idx[i], q);
      `CHK(q, timer_pkg::BYTE_RESET)
      wr(idx[i], 8'ha5 ^ 8'(i));
      rd(idx[i], q);
      `CHK(q, 8'ha5 ^ 8'(i))
    end
    apb(1'b0, 12'hf10, 8'h00, q, e);
    `CHK(e, 1'b1)
    `CHK(q, 8'h00)
  endtask

  task automatic pwm_test(input logic pol, input logic [2:0] pre);
    int n;
    int k;
    k = 1 << pre;
    wr(timer_pkg::IDX_CTL1, {1'b0, pol, pre, timer_pkg::MODE_PWM_SINGLE[2:0]});
    wr(timer_pkg::IDX_CTL0, 8'h00);
    wr16(timer_pkg::IDX_CNT_H, 16'h0100);
    wr16(timer_pkg::IDX_CMP_H, 16'h0102);
    wr16(timer_pkg::IDX_RLD_H, 16'h0105);
    `CHK(timer_out, pol)
    wr(timer_pkg::IDX_CTL1, {1'b1, pol, pre, timer_pkg::MODE_PWM_SINGLE[2:0]});
    run_len(pol, n);
    `CHK(n, 3 * k + 2)
    run_len(!pol, n);
    `CHK(n, 3 * k)
    run_len(pol, n);
    `CHK(n, 258 * k)
    wr(timer_pkg::IDX_CTL1, 8'h00);
  endtask

  task automatic cap_restart(input logic [1:0] icfg, input logic edg);
    logic [15:0] c;
    logic [7:0] s;
    int t;
    wr(timer_pkg::IDX_CTL1, 8'h00);
    wr(timer_pkg::IDX_CTL0, {1'b1, icfg, 5'h00});
    wr(timer_pkg::IDX_CTL1, {1'b0, edg, 6'h01});
    wr16(timer_pkg::IDX_CNT_H, 16'h0001);
    wr16(timer_pkg::IDX_RLD_H, 16'h0100);
    wr16(timer_pkg::IDX_CMP_H, 16'h0000);
    wr(timer_pkg::IDX_MASK, 8'h00);
    i_pin.drive(edg);
    rd(timer_pkg::IDX_STATUS, s);
    wr(timer_pkg::IDX_CTL1, {1'b1, edg, 6'h01});
    cyc(280);
    `CHK(irq, 1'b0)
    rd(timer_pkg::IDX_STATUS, s);
    `CHK(s[timer_pkg::ST_RELOAD], icfg != timer_pkg::ICFG_CAPTURE_ONLY)
    rd16(timer_pkg::IDX_CMP_H, c);
    `CHK(c, 16'h0000)
    wr(timer_pkg::IDX_MASK, 8'h03);
    i_pin.drive(!edg);
    t = cyc_n;
    cyc(12);
    `CHK(irq, icfg != timer_pkg::ICFG_RELOAD_ONLY)
    rd(timer_pkg::IDX_STATUS, s);
    cyc(2);
    `CHK(irq, 1'b0)
    `CHK(s[timer_pkg::ST_CAPTURE], icfg != timer_pkg::ICFG_RELOAD_ONLY)
    cyc(40);
    i_pin.drive(edg);
    cyc(50);
    i_pin.drive(!edg);
    t = cyc_n - t;
    cyc(12);
    rd16(timer_pkg::IDX_CMP_H, c);
    `CHK(c inside {[t - 2 : t + 2]}, 1'b1)
  endtask

  task automatic capture_test(input logic [3:0] mode);
    logic [15:0] a;
    logic [15:0] b;
    int t;
    wr(timer_pkg::IDX_CTL1, 8'h00);
    wr(timer_pkg::IDX_CTL0, {mode[3], 7'h00});
    wr16(timer_pkg::IDX_CNT_H, 16'h1000);
    wr16(timer_pkg::IDX_RLD_H, 16'hffff);
    i_pin.drive(1'b0);
    wr(timer_pkg::IDX_CTL1, {5'h10, mode[2:0]});
    t = cyc_n;
    cyc(30);
    i_pin.drive(1'b1);
    t = cyc_n - t;
    cyc(40);
    i_pin.drive(1'b0);
    cyc(12);
    rd16(timer_pkg::IDX_CMP_H, a);
    rd16(timer_pkg::IDX_CAP2_H, b);
    a = a - 16'h1000;
    `CHK(a inside {[t - 2 : t + 8]}, 1'b1)
    if (mode == timer_pkg::MODE_DEMOD)
    begin
      b = b - a - 16'h1000;
      `CHK(b inside {[39 : 43]}, 1'b1)
    end
    wr(timer_pkg::IDX_CTL1, 8'h00);
  endtask

  // Continuous mode toggles the output at every reload, so each level lasts one period.
  task automatic toggle_test;
    logic lvl;
    int n;
    wr(timer_pkg::IDX_CTL1, 8'h00);
    wr(timer_pkg::IDX_CTL0, 8'h00);
    wr16(timer_pkg::IDX_CNT_H, 16'h0001);
    wr16(timer_pkg::IDX_RLD_H, 16'h0004);
    lvl = timer_out;
    wr(timer_pkg::IDX_CTL1, {5'h10, timer_pkg::MODE_CONTINUOUS[2:0]});
    run_len(lvl, n);
    run_len(!lvl, n);
    `CHK(n, 4)
    run_len(lvl, n);
    `CHK(n, 4)
    wr(timer_pkg::IDX_CTL1, 8'h00);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // The tests take about 3000 cycles, so twenty times that means a hang.
  initial
  begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    results();
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    mismatches = 0;
    total_checks = 0;
    cyc_n = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reg_test();
    pwm_test(1'b1, 3'h0);
    pwm_test(1'b0, 3'h1);
    cap_restart(2'h0, 1'b0);
    cap_restart(timer_pkg::ICFG_CAPTURE_ONLY, 1'b1);
    cap_restart(timer_pkg::ICFG_RELOAD_ONLY, 1'b0);
    capture_test(timer_pkg::MODE_CAPTURE);
    capture_test(timer_pkg::MODE_CAP_CMP);
    capture_test(timer_pkg::MODE_DEMOD);
    toggle_test();
    results();
  end
endmodule
